// [rtl/ssj_consts.svh]
`ifndef SSJ_CONSTS_SVH
`define SSJ_CONSTS_SVH

`define SSJ_PIX_W 24
`define SSJ_HACT_W 14
`define SSJ_PPS_NUM 17
`define SSJ_PPS_AW 5
`define SSJ_VBR_BIT 5
`define SSJ_PIPE_LAST 2'h3

`define SSJ_ADDR_W 12
`define SSJ_OFF_CTRL 12'h000
`define SSJ_OFF_HACT 12'h004
`define SSJ_OFF_STAT 12'h008
`define SSJ_OFF_PPS_L 12'h100
`define SSJ_OFF_PPS_R 12'h180
`define SSJ_PPS_SPAN 12'h080

`define SSJ_CTRL_MODE_LSB 0
`define SSJ_CTRL_BJOIN 4
`define SSJ_CTRL_BJPRIM 5
`define SSJ_CTRL_DUAL 6
`define SSJ_CTRL_SLICE4 7
`define SSJ_CTRL_PANEL_SELF_REFRESH_V1 8
`define SSJ_CTRL_PANEL_SELF_REFRESH_V2 9
`define SSJ_CTRL_REPLAY 10
`define SSJ_CTRL_RST 32'h0000_0004

`endif

// [rtl/ssj_pkg.sv]
package ssj_pkg;
    typedef enum logic [2:0] {
        SSJ_BYPASS,
        SSJ_SINGLE,
        SSJ_USPLIT,
        SSJ_CSPLIT,
        SSJ_SPLIT_JOIN
    } ssj_mode_t;
endpackage

// [rtl/ssj_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssj_consts.svh"
interface ssj_if;
    // Configuration, driven by the transcoder end; pps_rdata comes back from the pipe end
    logic cfg_split;
    logic cfg_eng_l;
    logic cfg_eng_r;
    logic cfg_sjoin;
    logic cfg_bjoin;
    logic cfg_bj_primary;
    logic cfg_dual_link;
    logic [`SSJ_HACT_W-1:0] cfg_pic_width;
    logic [`SSJ_HACT_W-1:0] cfg_slice_width;
    logic pps_wr;
    logic pps_eng;
    logic [`SSJ_PPS_AW-1:0] pps_addr;
    logic [31:0] pps_wdata;
    logic [31:0] pps_rdata;
    // Streams and status, driven by the pipe end
    logic left_valid;
    logic [`SSJ_PIX_W-1:0] left_data;
    logic right_valid;
    logic [`SSJ_PIX_W-1:0] right_data;
    logic trans_en;
    logic port0_sync;
    logic cfg_bad;

    modport pipe (
        input cfg_split, cfg_eng_l, cfg_eng_r, cfg_sjoin, cfg_bjoin, cfg_bj_primary,
        input cfg_dual_link, cfg_pic_width, cfg_slice_width,
        input pps_wr, pps_eng, pps_addr, pps_wdata,
        output pps_rdata, left_valid, left_data, right_valid, right_data,
        output trans_en, port0_sync, cfg_bad
    );
    modport xcvr (
        output cfg_split, cfg_eng_l, cfg_eng_r, cfg_sjoin, cfg_bjoin, cfg_bj_primary,
        output cfg_dual_link, cfg_pic_width, cfg_slice_width,
        output pps_wr, pps_eng, pps_addr, pps_wdata,
        input pps_rdata, left_valid, left_data, right_valid, right_data,
        input trans_en, port0_sync, cfg_bad
    );
endinterface
`default_nettype wire

// [rtl/ssj_pipe.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssj_consts.svh"
module ssj_pipe (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [1:0] pipe_id_in,
    input wire logic pix_valid_in,
    input wire logic pix_sol_in,
    input wire logic [`SSJ_PIX_W-1:0] pix_data_in,
    input wire logic peer_valid_in,
    input wire logic [`SSJ_PIX_W-1:0] peer_data_in,
    output logic peer_valid_out,
    output logic [`SSJ_PIX_W-1:0] peer_data_out,
    ssj_if.pipe lnk
);
    logic [`SSJ_HACT_W-1:0] col_q;
    logic [`SSJ_HACT_W-1:0] col_cur;
    logic to_right;
    logic br_l_v_q;
    logic br_r_v_q;
    logic [`SSJ_PIX_W-1:0] br_l_d_q;
    logic [`SSJ_PIX_W-1:0] br_r_d_q;
    logic en_l_v_q;
    logic en_r_v_q;
    logic [`SSJ_PIX_W-1:0] en_l_d_q;
    logic [`SSJ_PIX_W-1:0] en_r_d_q;
    logic [31:0] pps_q [2][`SSJ_PPS_NUM];
    logic bj_ok;
    logic bj_prim;
    logic bj_sec;
    logic dual_ok;
    logic join_v;
    logic [`SSJ_PIX_W-1:0] join_d;

    // Column of the current pixel; a start-of-line pixel is column zero
    assign col_cur = pix_sol_in ? '0 : col_q;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            col_q <= '0;
        end
        else if (pix_valid_in)
        begin
            col_q <= col_cur + `SSJ_HACT_W'(1);
        end
    end

    // The split point is the branch picture width, half the line
    assign to_right = lnk.cfg_split && (col_cur >= lnk.cfg_pic_width);

    // Splitter stage: pixels keep their order inside each half
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            br_l_v_q <= 1'b0;
            br_r_v_q <= 1'b0;
            br_l_d_q <= '0;
            br_r_d_q <= '0;
        end
        else
        begin
            br_l_v_q <= pix_valid_in && !to_right;
            br_r_v_q <= pix_valid_in && to_right;
            if (pix_valid_in)
            begin
                br_l_d_q <= pix_data_in;
                br_r_d_q <= pix_data_in;
            end
        end
    end

    // Engine stage: one pixel slot per clock per engine. The entropy coder
    // sits outside this block; an enabled engine's slot carries its word.
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            en_l_v_q <= 1'b0;
            en_r_v_q <= 1'b0;
            en_l_d_q <= '0;
            en_r_d_q <= '0;
        end
        else
        begin
            en_l_v_q <= br_l_v_q;
            en_r_v_q <= br_r_v_q && (lnk.cfg_split || lnk.cfg_eng_r);
            en_l_d_q <= br_l_d_q;
            en_r_d_q <= br_r_d_q;
        end
    end

    // Separate parameter sets per engine
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int e = 0; e < 2; e++)
            begin
                for (int i = 0; i < `SSJ_PPS_NUM; i++)
                begin
                    pps_q[e][i] <= 32'h0000_0000;
                end
            end
        end
        else if (lnk.pps_wr && (lnk.pps_addr < `SSJ_PPS_AW'(`SSJ_PPS_NUM)))
        begin
            pps_q[lnk.pps_eng][lnk.pps_addr] <= lnk.pps_wdata;
        end
    end

    // Read port is combinational; the transcoder end registers it
    assign lnk.pps_rdata = (lnk.pps_addr < `SSJ_PPS_AW'(`SSJ_PPS_NUM)) ?
        pps_q[lnk.pps_eng][lnk.pps_addr] : 32'h0000_0000;

    // Pairing: lower pipe is primary and needs an upper neighbour
    always_comb
    begin
        bj_ok = lnk.cfg_bjoin && lnk.cfg_sjoin && lnk.cfg_eng_l && lnk.cfg_eng_r;
        if (lnk.cfg_bj_primary)
        begin
            bj_ok = bj_ok && (pipe_id_in != `SSJ_PIPE_LAST);
        end
        else
        begin
            bj_ok = bj_ok && (pipe_id_in != 2'h0);
        end
    end
    assign bj_prim = bj_ok && lnk.cfg_bj_primary;
    assign bj_sec = bj_ok && !lnk.cfg_bj_primary;
    // Dual link on one pipe is reserved for the first pipe
    assign dual_ok = !lnk.cfg_dual_link || (pipe_id_in == 2'h0);

    // Small joiner: with one pixel per clock in, the branches never fire
    // together, so the merge needs no storage; left words precede right
    always_comb
    begin
        join_v = en_l_v_q || en_r_v_q;
        join_d = en_l_v_q ? en_l_d_q : en_r_d_q;
        if (bj_prim && !join_v && peer_valid_in)
        begin
            join_v = 1'b1;
            join_d = peer_data_in;
        end
    end

    // Output multiplexers
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lnk.left_valid <= 1'b0;
            lnk.left_data <= '0;
            lnk.right_valid <= 1'b0;
            lnk.right_data <= '0;
            peer_valid_out <= 1'b0;
            peer_data_out <= '0;
        end
        else
        begin
            lnk.left_valid <= 1'b0;
            lnk.right_valid <= 1'b0;
            peer_valid_out <= 1'b0;
            if (bj_sec)
            begin
                peer_valid_out <= join_v;
                peer_data_out <= join_d;
            end
            else if (lnk.cfg_sjoin && lnk.cfg_split)
            begin
                lnk.left_valid <= join_v;
                lnk.left_data <= join_d;
            end
            else if (lnk.cfg_split)
            begin
                lnk.left_valid <= en_l_v_q;
                lnk.left_data <= en_l_d_q;
                lnk.right_valid <= en_r_v_q && dual_ok;
                lnk.right_data <= en_r_d_q;
            end
            else
            begin
                lnk.left_valid <= en_l_v_q;
                lnk.left_data <= en_l_d_q;
            end
        end
    end

    // Status toward the transcoder
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lnk.trans_en <= 1'b0;
            lnk.port0_sync <= 1'b0;
            lnk.cfg_bad <= 1'b0;
        end
        else
        begin
            lnk.trans_en <= !bj_sec;
            lnk.port0_sync <= lnk.cfg_dual_link && lnk.cfg_split && !lnk.cfg_sjoin
                && (pipe_id_in == 2'h0);
            lnk.cfg_bad <= (lnk.cfg_bjoin && !bj_ok) || !dual_ok;
        end
    end
endmodule
`default_nettype wire

// [rtl/ssj_xcvr.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssj_consts.svh"
module ssj_xcvr (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [`SSJ_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic port0_valid_out,
    output logic [`SSJ_PIX_W-1:0] port0_data_out,
    output logic port1_valid_out,
    output logic [`SSJ_PIX_W-1:0] port1_data_out,
    ssj_if.xcvr lnk
);
    logic [31:0] ctrl_q;
    logic [`SSJ_HACT_W-1:0] hact_q;
    ssj_pkg::ssj_mode_t mode;
    logic pps_hit;
    logic bj_req;
    logic bj_legal;

    // Default asks for two engines and the joiner, the low-clock setup
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= `SSJ_CTRL_RST;
            hact_q <= '0;
        end
        else if (wr_in)
        begin
            if (addr_in == `SSJ_OFF_CTRL)
            begin
                ctrl_q <= wdata_in;
            end
            if (addr_in == `SSJ_OFF_HACT)
            begin
                hact_q <= wdata_in[`SSJ_HACT_W-1:0];
            end
        end
    end

    assign mode = ssj_pkg::ssj_mode_t'(ctrl_q[`SSJ_CTRL_MODE_LSB +: 3]);
    assign bj_req = ctrl_q[`SSJ_CTRL_BJOIN];
    // Joining needs compression and the small joiner, and no refresh modes
    assign bj_legal = bj_req && (mode == ssj_pkg::SSJ_SPLIT_JOIN)
        && !ctrl_q[`SSJ_CTRL_PANEL_SELF_REFRESH_V1] && !ctrl_q[`SSJ_CTRL_PANEL_SELF_REFRESH_V2]
        && !ctrl_q[`SSJ_CTRL_REPLAY];

    // Mode decode; codes above the last mode fall back to bypass
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lnk.cfg_split <= 1'b0;
            lnk.cfg_eng_l <= 1'b0;
            lnk.cfg_eng_r <= 1'b0;
            lnk.cfg_sjoin <= 1'b0;
        end
        else
        begin
            unique case (mode)
                ssj_pkg::SSJ_BYPASS:
                begin
                    lnk.cfg_split <= 1'b0;
                    lnk.cfg_eng_l <= 1'b0;
                    lnk.cfg_eng_r <= 1'b0;
                    lnk.cfg_sjoin <= 1'b0;
                end
                ssj_pkg::SSJ_SINGLE:
                begin
                    lnk.cfg_split <= 1'b0;
                    lnk.cfg_eng_l <= 1'b1;
                    lnk.cfg_eng_r <= 1'b0;
                    lnk.cfg_sjoin <= 1'b0;
                end
                ssj_pkg::SSJ_USPLIT:
                begin
                    lnk.cfg_split <= 1'b1;
                    lnk.cfg_eng_l <= 1'b0;
                    lnk.cfg_eng_r <= 1'b0;
                    lnk.cfg_sjoin <= 1'b0;
                end
                ssj_pkg::SSJ_CSPLIT:
                begin
                    lnk.cfg_split <= 1'b1;
                    lnk.cfg_eng_l <= 1'b1;
                    lnk.cfg_eng_r <= 1'b1;
                    lnk.cfg_sjoin <= 1'b0;
                end
                ssj_pkg::SSJ_SPLIT_JOIN:
                begin
                    lnk.cfg_split <= 1'b1;
                    lnk.cfg_eng_l <= 1'b1;
                    lnk.cfg_eng_r <= 1'b1;
                    lnk.cfg_sjoin <= 1'b1;
                end
                default:
                begin
                    lnk.cfg_split <= 1'b0;
                    lnk.cfg_eng_l <= 1'b0;
                    lnk.cfg_eng_r <= 1'b0;
                    lnk.cfg_sjoin <= 1'b0;
                end
            endcase
        end
    end

    // Branch geometry and pairing
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lnk.cfg_bjoin <= 1'b0;
            lnk.cfg_bj_primary <= 1'b0;
            lnk.cfg_dual_link <= 1'b0;
            lnk.cfg_pic_width <= '0;
            lnk.cfg_slice_width <= '0;
        end
        else
        begin
            lnk.cfg_bjoin <= bj_legal;
            lnk.cfg_bj_primary <= ctrl_q[`SSJ_CTRL_BJPRIM];
            lnk.cfg_dual_link <= ctrl_q[`SSJ_CTRL_DUAL];
            lnk.cfg_pic_width <= (mode >= ssj_pkg::SSJ_USPLIT) ? (hact_q >> 1) : hact_q;
            lnk.cfg_slice_width <= ctrl_q[`SSJ_CTRL_SLICE4] ? (hact_q >> 2) : hact_q;
        end
    end

    // Parameter window is forwarded in the same cycle, so a parameter read
    // answers one cycle after its strobe like every other register
    assign pps_hit = (addr_in >= `SSJ_OFF_PPS_L)
        && (addr_in < (`SSJ_OFF_PPS_R + `SSJ_PPS_SPAN));
    assign lnk.pps_wr = wr_in && pps_hit;
    assign lnk.pps_eng = (addr_in >= `SSJ_OFF_PPS_R);
    assign lnk.pps_addr = addr_in[`SSJ_PPS_AW+1:2];
    // The engine cannot run variable bit rate, so that flag is never stored
    assign lnk.pps_wdata = (addr_in[`SSJ_PPS_AW+1:2] == '0) ?
        (wdata_in & ~(32'h1 << `SSJ_VBR_BIT)) : wdata_in;

    // Read data for registers of this end; other addresses read the pipe's parameter words
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= 32'h0000_0000;
        end
        else if (rd_in && addr_in == `SSJ_OFF_CTRL)
        begin
            rdata_out <= ctrl_q;
        end
        else if (rd_in && addr_in == `SSJ_OFF_HACT)
        begin
            rdata_out <= {{(32-`SSJ_HACT_W){1'b0}}, hact_q};
        end
        else if (rd_in && addr_in == `SSJ_OFF_STAT)
        begin
            rdata_out <= {28'h0000000, lnk.cfg_bad, bj_req && !bj_legal,
                lnk.port0_sync, lnk.trans_en};
        end
        else
        begin
            rdata_out <= lnk.pps_rdata;
        end
    end

    // Port outputs: left feeds port 0 only while this transcoder is on
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            port0_valid_out <= 1'b0;
            port0_data_out <= '0;
            port1_valid_out <= 1'b0;
            port1_data_out <= '0;
        end
        else
        begin
            port0_valid_out <= lnk.left_valid && lnk.trans_en;
            port0_data_out <= lnk.left_data;
            port1_valid_out <= lnk.right_valid;
            port1_data_out <= lnk.right_data;
        end
    end
endmodule
`default_nettype wire

// [dv/ssj_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssj_consts.svh"
module ssj_props (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic cfg_split,
    input wire logic cfg_eng_l,
    input wire logic cfg_eng_r,
    input wire logic cfg_sjoin,
    input wire logic cfg_bjoin,
    input wire logic cfg_bj_primary,
    input wire logic cfg_dual_link,
    input wire logic [`SSJ_HACT_W-1:0] cfg_pic_width,
    input wire logic [`SSJ_HACT_W-1:0] cfg_slice_width,
    input wire logic left_valid,
    input wire logic right_valid,
    input wire logic trans_en,
    input wire logic port0_sync,
    input wire logic cfg_bad
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    AST_BJ_GATED:
    assert property (cfg_bjoin |-> cfg_sjoin && cfg_eng_l && cfg_eng_r)
        else $error("big join enabled without joiner and both engines");
    AST_JOIN_NEEDS_SPLIT:
    assert property (cfg_sjoin |-> cfg_split && cfg_eng_l && cfg_eng_r)
        else $error("joiner enabled without split and both engines");
    AST_ENG_R_SPLIT:
    assert property (cfg_eng_r |-> cfg_split)
        else $error("right engine enabled without split");
    AST_JOIN_NO_RIGHT:
    assert property (cfg_sjoin [*4] |-> !right_valid)
        else $error("joined data on right output");
    AST_BYPASS_NO_RIGHT:
    assert property (!cfg_split [*4] |-> !right_valid)
        else $error("right output active without split");
    AST_SLICE_QUARTER:
    assert property (cfg_split && cfg_slice_width < cfg_pic_width
        |-> cfg_slice_width == (cfg_pic_width >> 1))
        else $error("slice width not half of branch width");
    AST_SEC_SILENT:
    assert property ((cfg_bjoin && !cfg_bj_primary && !cfg_bad) [*4] |-> !trans_en && !left_valid)
        else $error("secondary pipe drives its transcoder");
    AST_DUAL_SYNC:
    assert property ((cfg_dual_link && !cfg_bad) [*3] |-> port0_sync)
        else $error("dual link without port sync");
    AST_BAD_NO_RIGHT:
    assert property ((cfg_bad && cfg_dual_link) [*4] |-> !right_valid)
        else $error("refused dual link still drives right");

    cover property (cfg_bjoin && cfg_bj_primary);
    cover property (cfg_sjoin ##1 left_valid);
    cover property (cfg_split && !cfg_sjoin && right_valid);
endmodule
`default_nettype wire

// [dv/dsc_stream_split_join_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssj_consts.svh"
module dsc_stream_split_join_tb;
    localparam logic [31:0] bj = 32'h1 << `SSJ_CTRL_BJOIN;
    localparam logic [31:0] prim = 32'h1 << `SSJ_CTRL_BJPRIM;
    logic clk_sys_in = 1'h0;
    logic rst_in = 1'h1;
    logic [`SSJ_ADDR_W-1:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] r;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [1:0] pipe_id = 2'h0;
    logic pv = 1'h0;
    logic psol = 1'h0;
    logic peer_v = 1'h0;
    logic [`SSJ_PIX_W-1:0] pd = 24'h0;
    logic [`SSJ_PIX_W-1:0] peer_d = 24'h0;
    logic p0v, p1v, pov;
    logic [`SSJ_PIX_W-1:0] p0d, p1d, pod;
    logic [`SSJ_PIX_W-1:0] q0[$];
    logic [`SSJ_PIX_W-1:0] q1[$];
    int nsec = 0;
    int bad_count = 0;
    int compares = 0;
    int m;
    ssj_if lnk();
    ssj_pipe u_ssj_pipe (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .pipe_id_in(pipe_id),
        .pix_valid_in(pv), .pix_sol_in(psol), .pix_data_in(pd), .peer_valid_in(peer_v),
        .peer_data_in(peer_d), .peer_valid_out(pov), .peer_data_out(pod), .lnk(lnk));
    ssj_xcvr u_ssj_xcvr (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .port0_valid_out(p0v),
        .port0_data_out(p0d), .port1_valid_out(p1v), .port1_data_out(p1d), .lnk(lnk));
    ssj_props u_ssj_props (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .cfg_split(lnk.cfg_split), .cfg_eng_l(lnk.cfg_eng_l), .cfg_eng_r(lnk.cfg_eng_r),
        .cfg_sjoin(lnk.cfg_sjoin), .cfg_bjoin(lnk.cfg_bjoin),
        .cfg_bj_primary(lnk.cfg_bj_primary), .cfg_dual_link(lnk.cfg_dual_link),
        .cfg_pic_width(lnk.cfg_pic_width), .cfg_slice_width(lnk.cfg_slice_width),
        .left_valid(lnk.left_valid), .right_valid(lnk.right_valid), .trans_en(lnk.trans_en),
        .port0_sync(lnk.port0_sync), .cfg_bad(lnk.cfg_bad));

    always #12.5 clk_sys_in = ~clk_sys_in;

    always @(posedge clk_sys_in)
    begin
        if (p0v) q0.push_back(p0d);
        if (p1v) q1.push_back(p1d);
        if (pov) nsec++;
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys_in);
        wr <= 1'h0;
    endtask

    // Read data of CTRL, HACT and STAT stand only in the cycle after the strobe; taken at its closing edge
    task automatic rreg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys_in);
        rd <= 1'h0;
        @(posedge clk_sys_in);
        d = rdata;
    endtask

    task automatic cfg(input logic [31:0] c, input logic [13:0] h);
        wreg(`SSJ_OFF_HACT, {18'h0, h});
        wreg(`SSJ_OFF_CTRL, c);
        repeat (4) @(posedge clk_sys_in);
    endtask

    task automatic st(input logic [31:0] mask, input logic [31:0] e);
        rreg(`SSJ_OFF_STAT, r);
        chk("status", e, r & mask);
    endtask

    task automatic send(input int n, input logic [23:0] b, input bit peer);
        int i;
        q0.delete();
        q1.delete();
        nsec = 0;
        for (i = 0; i < n; i++)
        begin
            @(posedge clk_sys_in);
            pv <= !peer;
            psol <= !peer && i == 0;
            pd <= b + 24'(i);
            peer_v <= peer;
            peer_d <= b + 24'(i);
        end
        @(posedge clk_sys_in);
        pv <= 1'h0;
        psol <= 1'h0;
        peer_v <= 1'h0;
        repeat (10) @(posedge clk_sys_in);
    endtask

    task automatic chk_q(input bit s, input int n, input logic [23:0] b);
        int i;
        chk(s ? "port1 count" : "port0 count", 32'(n), s ? 32'(q1.size()) : 32'(q0.size()));
        for (i = 0; i < n && i < (s ? q1.size() : q0.size()); i++)
            chk(s ? "port1 data" : "port0 data", 32'(b + 24'(i)), 32'(s ? q1[i] : q0[i]));
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        rreg(`SSJ_OFF_CTRL, r);
        chk("ctrl reset", `SSJ_CTRL_RST, r);
        $display("reset test done");
        for (m = 0; m < 5; m++)
        begin
            cfg(32'(m), 14'h0008);
            send(8, 24'(m) << 16, 1'h0);
            chk_q(1'h0, (m == 2 || m == 3) ? 4 : 8, 24'(m) << 16);
            chk_q(1'h1, (m == 2 || m == 3) ? 4 : 0, (24'(m) << 16) + 24'h4);
        end
        $display("mode test done");
        wreg(`SSJ_OFF_PPS_L, 32'hFFFFFFFF & ~(32'h1 << `SSJ_VBR_BIT));
        wreg(`SSJ_OFF_PPS_R, 32'h00001214);
        wreg(`SSJ_OFF_PPS_L + 12'h040, 32'hA5A50001);
        wreg(12'h0FC, 32'h00000001);
        rreg(`SSJ_OFF_PPS_L, r);
        chk("pps left 0", 32'hFFFFFFFF & ~(32'h1 << `SSJ_VBR_BIT), r);
        rreg(`SSJ_OFF_PPS_R, r);
        chk("pps right 0", 32'h00001214, r);
        rreg(`SSJ_OFF_PPS_L + 12'h040, r);
        chk("pps left 16", 32'hA5A50001, r);
        rreg(`SSJ_OFF_CTRL, r);
        chk("ctrl after unmapped write", 32'h4, r);
        $display("parameter test done");
        cfg(32'h83, 14'h0010);
        chk("pic width", 32'h8, 32'(lnk.cfg_pic_width));
        chk("slice width", 32'h4, 32'(lnk.cfg_slice_width));
        cfg(32'h1, 14'h0010);
        chk("pic width single", 32'h10, 32'(lnk.cfg_pic_width));
        $display("width test done");
        cfg(bj | 32'h3, 14'h0010);
        st(32'h4, 32'h4);
        cfg(bj | 32'h2, 14'h0010);
        st(32'h4, 32'h4);
        for (m = `SSJ_CTRL_PANEL_SELF_REFRESH_V1; m <= `SSJ_CTRL_REPLAY; m++)
        begin
            cfg(bj | 32'h4 | (32'h1 << m), 14'h0010);
            st(32'h4, 32'h4);
        end
        cfg(bj | prim | 32'h4, 14'h0010);
        st(32'hD, 32'h1);
        send(4, 24'h300000, 1'h1);
        chk_q(1'h0, 4, 24'h300000);
        pipe_id <= 2'h3;
        repeat (4) @(posedge clk_sys_in);
        st(32'h8, 32'h8);
        pipe_id <= 2'h1;
        cfg(bj | 32'h4, 14'h0010);
        st(32'h1, 32'h0);
        send(4, 24'h400000, 1'h0);
        chk("peer words", 32'h4, 32'(nsec));
        chk("secondary port0", 32'h0, 32'(q0.size()));
        $display("big join test done");
        pipe_id <= 2'h0;
        cfg(32'h43, 14'h0008);
        st(32'hA, 32'h2);
        send(8, 24'h500000, 1'h0);
        chk_q(1'h0, 4, 24'h500000);
        chk_q(1'h1, 4, 24'h500004);
        pipe_id <= 2'h1;
        repeat (4) @(posedge clk_sys_in);
        st(32'h8, 32'h8);
        send(8, 24'h600000, 1'h0);
        chk_q(1'h1, 0, 24'h600004);
        $display("dual link test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
